// ===== acd_pkg.sv
// Functional notes
// R1 - Aux clock output comes from system clock, gated by enable bit 3, reset off.
// R2 - Divider code 0..8 gives /1,/2,/3,/4,/5.5,/6,/8,/12,/16; 9..15 reserved.
// R3 - Aux clock reaches the pin only when the pin selection also picks it.
// R4 - Timeout tick is derived from the 256 kHz clock for debounce and volume timeouts.
// R5 - Timeout tick runs only while its enable bit 0 is set; resets to off.
// R6 - Half select bit 12: 1 doubles tick frequency, 0 passes it.
// R7 - Quad select bit 13: 1 multiplies tick frequency by four.
// R8 - Div16 select bit 14: 1 divides tick frequency by sixteen.
// R9 - Tick frequency spans 1000 Hz down to 7.8125 Hz.
// R10 - Software never runs record and playback at doubled rate together.
// R11 - Doubled playback: software programs rate select to half the wanted rate.
// R12 - Doubled playback: software clears record enables and playback high oversampling.
// R13 - Software keeps the equaliser disabled at doubled rates.
// R14 - Doubled rate: rate 101, ratio 0001, bit clock divider 00010, frame 040h.
// R15 - Doubled recording: software clears playback enables, programs half rate.
// R16 - Doubled recording: software clears record oversampling, test and bias bits.
// R17 - Doubled rates: system clock comes from the master clock input.
// R18 - System clock, hence aux clock, toggles only while system clock enable set.
// R19 - Rate select code 101 means 44.1/48 kHz base, 88.2/96 kHz doubled.
// R20 - 256 kHz clock prescaled by 2048 to a 125 Hz base tick.
package acd_pkg;
  localparam int unsigned ADDR_W = 10;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_RATE_0    = 8'h14;
  localparam logic [7:0] IDX_RATE_1    = 8'h15;
  localparam logic [7:0] IDX_RATE_2    = 8'h16;
  localparam logic [7:0] IDX_PORT_2    = 8'h1a;
  localparam logic [7:0] IDX_STATUS    = 8'h1f;
  // Field positions
  localparam int unsigned TICK_EN_BIT  = 0;
  localparam int unsigned SYS_EN_BIT   = 2;
  localparam int unsigned AUX_EN_BIT   = 3;
  localparam int unsigned HALF_BIT     = 12;
  localparam int unsigned QUAD_BIT     = 13;
  localparam int unsigned DIV16_BIT    = 14;
  localparam int unsigned AUX_DIV_LSB  = 8;
  localparam logic [2:0] FS_BASE_48K   = 3'h5;
  localparam logic [3:0] AUX_DIV_MAX   = 4'h8;
  // Reset values
  localparam logic [15:0] RATE_0_RST   = 16'h0000;
  localparam logic [15:0] RATE_1_RST   = 16'h0c05;
  localparam logic [15:0] RATE_2_RST   = 16'h0000;
  localparam logic [15:0] PORT_2_RST   = 16'h0000;
  // Timeout tick timing, counted in 256 kHz pulses
  localparam int unsigned OSC_HZ       = 256000;
  localparam int unsigned BASE_TICK_HZ = 125;
  localparam logic [15:0] TICK_BASE_DIV = 16'(OSC_HZ / BASE_TICK_HZ);

  typedef struct packed {
    logic [15:0] rate0;
    logic [15:0] rate1;
    logic [15:0] rate2;
    logic [15:0] port2;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
    logic        sys_prev;
    logic [4:0]  half_cnt;
    logic        aux_lvl;
    logic        pin;
  } acd_state_type;

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } acd_tick_state_type;
endpackage

// ===== acd_tick_if.sv
`timescale 1ns/1ps
interface acd_tick_if;
  logic en;
  logic half;
  logic quad;
  logic div16;
  logic osc_pulse;
  logic tick;
  modport ctl (output en, half, quad, div16, osc_pulse, input tick);
  modport gen (input en, half, quad, div16, osc_pulse, output tick);
endinterface

// ===== acd_tick_gen.sv
`timescale 1ns/1ps
module acd_tick_gen
  import acd_pkg::*;
(
  input  wire logic pclk,    // Clock
  input  wire logic presetn, // Async reset
  acd_tick_if.gen   tif      // Tick controls
);
  acd_tick_state_type s_q;
  acd_tick_state_type s_d;
  logic [15:0]        period;

  function automatic logic [15:0] tick_period(input logic half, input logic quad, input logic div16);
    logic [15:0] p;
    p = TICK_BASE_DIV;         // R20
    if (half) begin
      p = p >> 1;              // R6
    end
    if (quad) begin
      p = p >> 2;              // R7
    end
    if (div16) begin
      p = p << 4;              // R8
    end
    return p;                  // R9
  endfunction

  assign period   = tick_period(tif.half, tif.quad, tif.div16);
  assign tif.tick = s_q.tick;

  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (!tif.en) begin
      s_d.cnt = 16'h0000;      // R5
    end else if (tif.osc_pulse) begin
      // Selector change mid-count: restart rather than run past the new end
      if (s_q.cnt >= period - 16'h0001) begin
        s_d.cnt  = 16'h0000;
        s_d.tick = 1'b1;       // R4
      end else begin
        s_d.cnt = s_q.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  tick_off_a: assert property (!tif.en |=> !s_q.tick) // R5
    else $error("tick while disabled");
  tick_cause_a: assert property (s_q.tick |-> $past(tif.osc_pulse) && $past(tif.en)) // R4
    else $error("tick without 256 kHz pulse");
  tick_period_a: assert property (
      s_q.tick && $stable(period) |-> $past(s_q.cnt) == period - 16'h0001) // R9
    else $error("tick period wrong");
  tick_fast_a: assert property (
      tif.half && tif.quad && !tif.div16 |-> period == 16'h0100) // R7
    else $error("fastest tick not 1 ms");
endmodule

// ===== acd_top.sv
`timescale 1ns/1ps
module acd_top
  import acd_pkg::*;
(
  input  wire logic              pclk,          // APB clock, 200 MHz
  input  wire logic              presetn,       // Async reset
  input  wire logic              psel,          // APB select
  input  wire logic              penable,       // APB enable
  input  wire logic              pwrite,        // APB direction
  input  wire logic [ADDR_W-1:0] paddr,         // APB byte address
  input  wire logic [31:0]       pwdata,        // APB write data
  output logic      [31:0]       prdata,        // APB read data
  output logic                   pready,        // APB ready
  output logic                   pslverr,       // APB error
  input  wire logic              system_clock_in,     // System clock waveform
  input  wire logic              osc256k_pulse, // One pulse per 256 kHz period
  input  wire logic              gpio_aux_sel,  // Pin set to carry aux clock
  output logic                   aux_clock_out, // Aux clock toward the pin
  output logic                   timeout_tick   // Timeout tick pulse
);
  acd_state_type s_q;
  acd_state_type s_d;
  acd_tick_if    tif ();

  logic          xfer;
  logic          sys_edge;
  logic          aux_run;
  logic [3:0]    div_code;
  logic [4:0]    half_lim;
  logic [15:0]   status;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    return {idx, 2'b00};
  endfunction

  // Half periods of system clock per aux level; zero marks reserved
  function automatic logic [4:0] div_half(input logic [3:0] code, input logic lvl);
    case (code)
      4'h0:    div_half = 5'h01;
      4'h1:    div_half = 5'h02;
      4'h2:    div_half = 5'h03;
      4'h3:    div_half = 5'h04;
      4'h4:    div_half = lvl ? 5'h05 : 5'h06; // 11 halves per period
      4'h5:    div_half = 5'h06;
      4'h6:    div_half = 5'h08;
      4'h7:    div_half = 5'h0c;
      4'h8:    div_half = 5'h10;
      default: div_half = 5'h00;
    endcase
  endfunction

  // ************************************************************
  // Combinational view
  // ************************************************************
  assign xfer     = psel && penable && s_q.ready;
  assign sys_edge = system_clock_in != s_q.sys_prev;
  assign div_code = s_q.port2[AUX_DIV_LSB +: 4];
  assign half_lim = div_half(div_code, s_q.aux_lvl);
  assign aux_run  = s_q.rate2[SYS_EN_BIT] && s_q.rate2[AUX_EN_BIT] // R1 R18
                    && (half_lim != 5'h00);                       // R2
  assign status   = {11'h000,
                     s_q.rate1[2:0] == FS_BASE_48K,                // R19
                     tif.tick,
                     div_code > AUX_DIV_MAX,
                     aux_run,
                     s_q.aux_lvl};

  // ************************************************************
  // Tick generator
  // ************************************************************
  assign tif.en        = s_q.rate2[TICK_EN_BIT];  // R5
  assign tif.half      = s_q.rate2[HALF_BIT];     // R6
  assign tif.quad      = s_q.rate0[QUAD_BIT];     // R7
  assign tif.div16     = s_q.rate0[DIV16_BIT];    // R8
  assign tif.osc_pulse = osc256k_pulse;           // R4

  acd_tick_gen u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .tif     (tif)
  );

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    s_d          = s_q;
    s_d.sys_prev = system_clock_in;
    // One wait state so read data and ready both leave flops
    s_d.ready    = psel && penable && !s_q.ready;
    if (psel && penable && !s_q.ready) begin
      s_d.rdata = 32'h0000_0000;
      s_d.err   = 1'b0;
      if (paddr == byte_addr(IDX_RATE_0)) begin
        s_d.rdata = {16'h0000, s_q.rate0};
      end else if (paddr == byte_addr(IDX_RATE_1)) begin
        s_d.rdata = {16'h0000, s_q.rate1};
      end else if (paddr == byte_addr(IDX_RATE_2)) begin
        s_d.rdata = {16'h0000, s_q.rate2};
      end else if (paddr == byte_addr(IDX_PORT_2)) begin
        s_d.rdata = {16'h0000, s_q.port2};
      end else if (paddr == byte_addr(IDX_STATUS)) begin
        s_d.rdata = {16'h0000, status};
      end else begin
        s_d.err = 1'b1;
      end
    end
    if (xfer && pwrite) begin
      if (paddr == byte_addr(IDX_RATE_0)) begin
        s_d.rate0 = pwdata[15:0];
      end else if (paddr == byte_addr(IDX_RATE_1)) begin
        s_d.rate1 = pwdata[15:0];
      end else if (paddr == byte_addr(IDX_RATE_2)) begin
        s_d.rate2 = pwdata[15:0];
      end else if (paddr == byte_addr(IDX_PORT_2)) begin
        s_d.port2 = pwdata[15:0];
      end
    end
    // Aux divider counts system clock half periods
    if (!aux_run) begin
      s_d.aux_lvl  = 1'b0;   // R1
      s_d.half_cnt = 5'h00;
    end else if (sys_edge) begin
      if (s_q.half_cnt + 5'h01 >= half_lim) begin
        s_d.aux_lvl  = !s_q.aux_lvl;  // R2
        s_d.half_cnt = 5'h00;
      end else begin
        s_d.half_cnt = s_q.half_cnt + 5'h01;
      end
    end
    s_d.pin = s_d.aux_lvl && gpio_aux_sel; // R3
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q          <= '0;
      s_q.rate0    <= RATE_0_RST;
      s_q.rate1    <= RATE_1_RST;
      s_q.rate2    <= RATE_2_RST;
      s_q.port2    <= PORT_2_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata        = s_q.rdata;
  assign pready        = s_q.ready;
  assign pslverr       = s_q.err;
  assign aux_clock_out = s_q.pin;
  assign timeout_tick  = tif.tick;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence acc_wait;
    psel && penable && !pready;
  endsequence

  sequence wr_rate2;
    psel && penable && pready && pwrite && paddr == byte_addr(IDX_RATE_2);
  endsequence

  apb_wait_a: assert property (acc_wait |=> pready ##1 !pready)
    else $error("ready not after one wait");
  rate2_write_a: assert property (wr_rate2 |=> s_q.rate2 == $past(pwdata[15:0])) // R1
    else $error("control write lost");
  bad_addr_a: assert property (acc_wait ##1 pready && pslverr |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  aux_gate_a: assert property (!s_q.rate2[SYS_EN_BIT] |=> !aux_clock_out) // R18
    else $error("aux clock without system clock");
  pin_sel_a: assert property (!gpio_aux_sel |=> !aux_clock_out) // R3
    else $error("aux clock on unselected pin");
  div_one_a: assert property (
      aux_run && div_code == 4'h0 && sys_edge |=> s_q.aux_lvl != $past(s_q.aux_lvl)) // R2
    else $error("divide by one not following");
  reserved_a: assert property (div_code > AUX_DIV_MAX |=> !s_q.aux_lvl) // R2
    else $error("reserved divider code runs");
  // Checked through the read path, not against the status wire itself
  fs_base_a: assert property (
      psel && penable && pready && !pwrite && paddr == byte_addr(IDX_STATUS)
      |-> prdata[4] == (s_q.rate1[2:0] == FS_BASE_48K)) // R19
    else $error("base rate flag wrong");
endmodule

// ===== acd_top_tb.sv
`timescale 1ns/1ps
module acd_top_tb;
  import acd_pkg::*;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              system_clock_in = 1'b0;
  logic              osc256k_pulse = 1'b0;
  logic              gpio_aux_sel = 1'b1;
  logic              aux_clock_out;
  logic              timeout_tick;
  logic              aux_prev = 1'b0;
  logic [31:0]       rd;
  logic              er;
  int                fails = 0;
  int                comparisons = 0;
  int                pcount = 0;
  int                scount = 0;
  int                sdiv = 0;

  acd_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .system_clock_in(system_clock_in), .osc256k_pulse(osc256k_pulse), .gpio_aux_sel(gpio_aux_sel),
    .aux_clock_out(aux_clock_out), .timeout_tick(timeout_tick));

  always #2.5 pclk = ~pclk;

  // ****************************************
  // Slow sources: system_clock level every 8 cycles so pipeline latency stays below it
  // ****************************************
  always @(posedge pclk) begin
    osc256k_pulse <= ~osc256k_pulse;
    aux_prev      <= aux_clock_out;
    if (osc256k_pulse) pcount <= pcount + 1;
    if (sdiv == 7) begin
      system_clock_in <= ~system_clock_in;
      scount    <= scount + 1;
      sdiv      <= 0;
    end else sdiv <= sdiv + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    chk(32'(n), 32'h2);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp, input logic experr);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp);
    chk({31'h0, er}, {31'h0, experr});
  endtask

  task automatic wait_ev(input logic aux);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while ((aux ? !(aux_clock_out === 1'b1 && aux_prev === 1'b0) : timeout_tick !== 1'b1) && n < 70000);
    if (n >= 70000) fails++;
  endtask

  task automatic tick_period(input logic [2:0] sel, input int p);
    int t0;
    apb(1'b1, IDX_RATE_2, 32'h0);
    apb(1'b1, IDX_RATE_0, {17'h0, sel[2], sel[1], 13'h0});
    apb(1'b1, IDX_RATE_2, {19'h0, sel[0], 11'h0, 1'b1});
    wait_ev(1'b0);
    t0 = pcount;
    wait_ev(1'b0);
    chk(32'(pcount - t0), 32'(p));
  endtask

  task automatic aux_period(input logic [3:0] code, input int n2);
    int s0;
    apb(1'b1, IDX_PORT_2, {20'h0, code, 8'h0});
    wait_ev(1'b1);
    wait_ev(1'b1);
    s0 = scount;
    wait_ev(1'b1);
    chk(32'(scount - s0), 32'(n2));
  endtask

  // Output must stay low for 400 cycles after a short settle
  task automatic quiet(input logic aux);
    logic hi;
    hi = 1'b0;
    repeat (20) @(posedge pclk);
    repeat (400) begin
      @(posedge pclk);
      if ((aux ? aux_clock_out : timeout_tick) !== 1'b0) hi = 1'b1;
    end
    chk({31'h0, hi}, 32'h0);
  endtask

  task automatic conclude();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #400000;
    fails++;
    conclude();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(IDX_RATE_0, 32'h0, 1'b0);
    rdchk(IDX_RATE_1, 32'h0c05, 1'b0);
    rdchk(IDX_RATE_2, 32'h0, 1'b0);
    rdchk(IDX_PORT_2, 32'h0, 1'b0);
    rdchk(IDX_STATUS, 32'h10, 1'b0);
    apb(1'b1, IDX_RATE_1, 32'h0c00);
    rdchk(IDX_STATUS, 32'h0, 1'b0);
    apb(1'b1, IDX_RATE_1, 32'h0405);
    rdchk(IDX_RATE_1, 32'h0405, 1'b0);
    apb(1'b1, IDX_STATUS, 32'hffff);
    rdchk(IDX_STATUS, 32'h10, 1'b0);
    apb(1'b1, 8'hfc, 32'h1234);
    chk({31'h0, er}, 32'h1);
    rdchk(8'hfc, 32'h0, 1'b1);
    $display("test registers done");
    tick_period(3'b011, 256);
    tick_period(3'b010, 512);
    tick_period(3'b001, 1024);
    tick_period(3'b000, 2048);
    tick_period(3'b111, 4096);
    apb(1'b1, IDX_RATE_2, 32'h0);
    quiet(1'b0);
    $display("test tick done");
    quiet(1'b1);
    apb(1'b1, IDX_RATE_2, 32'h000c);
    aux_period(4'h0, 2);
    aux_period(4'h1, 4);
    aux_period(4'h2, 6);
    aux_period(4'h3, 8);
    aux_period(4'h4, 11);
    aux_period(4'h5, 12);
    aux_period(4'h6, 16);
    aux_period(4'h7, 24);
    aux_period(4'h8, 32);
    apb(1'b1, IDX_PORT_2, 32'h0900);
    quiet(1'b1);
    rdchk(IDX_STATUS, 32'h14, 1'b0);
    apb(1'b1, IDX_PORT_2, 32'h0000);
    gpio_aux_sel <= 1'b0;
    quiet(1'b1);
    gpio_aux_sel <= 1'b1;
    apb(1'b1, IDX_RATE_2, 32'h0008);
    quiet(1'b1);
    apb(1'b1, IDX_RATE_2, 32'h0004);
    quiet(1'b1);
    $display("test aux clock done");
    conclude();
  end
endmodule
